// file: core/ccd_pkg.sv
// Shared constants and types for the serial control channel ends
`default_nettype none
package ccd_pkg;
	// Timing
	localparam int CLK_NS      = 8;
	localparam int FRAME_NS    = 125000;
	localparam int FRAME_BITS  = 32;
	localparam int BIT_CYC     = FRAME_NS / (CLK_NS * FRAME_BITS);
	localparam int BYTE_BITS   = 8;
	localparam int DATA_FIRST  = 1;
	// Recommended fast adaptation spans, in frames
	localparam int FAST_FRAMES_160 = 240;
	localparam int FAST_FRAMES_80  = 480;
	localparam int FAST_W          = 9;
	// Common byte fields
	localparam int SEL0_BIT = 0;
	localparam int SEL1_BIT = 1;
	// line_control fields
	localparam int DIAG_CLEAR_N_BIT = 2;
	localparam int LINE_RATE_BIT    = 3;
	localparam int SIG_IN_BEARER_BIT = 4;
	localparam int SCRAMBLER_BIT    = 5;
	localparam int FAST_ADAPT_BIT   = 6;
	localparam int TX_HK_BIT        = 7;
	// diagnostic_control fields
	localparam int LOOP_LO_BIT      = 2;
	localparam int LOOP_HI_BIT      = 3;
	localparam int RESYNC_LOSS_BIT  = 4;
	localparam int POLY_EXCH_BIT    = 5;
	localparam int LINE_MUTE_BIT    = 6;
	// Select codes, as {bit1, bit0}
	localparam logic [1:0] SEL_CTRL = 2'h0;
	localparam logic [1:0] SEL_DIAG = 2'h2;
	// Loopback codes, as {bit3, bit2}
	localparam logic [1:0] LB_NONE = 2'h0;
	localparam logic [1:0] LB_SYS  = 2'h2;
	localparam logic [1:0] LB_LINE = 2'h1;
	localparam logic [1:0] LB_FAR  = 2'h3;
	// Default modes
	localparam logic [7:0] DEF_MASK  = 8'hF0;
	localparam logic [7:0] DEF1_VAL  = 8'h00;
	localparam logic [7:0] DEF2_VAL  = 8'h08; // Only the rate bit set: 160 kbit/s
	localparam logic [7:0] ALL_ONES  = 8'hFF;
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] DIAG_RST  = 8'h00;
	// Receive and transmit sequencing
	typedef enum logic [1:0] {
		CCD_RX_WAIT  = 2'h1,
		CCD_RX_SHIFT = 2'h2
	} ccd_rx_e;
	typedef enum logic [2:0] {
		CCD_TX_PULSE = 3'h1,
		CCD_TX_DATA  = 3'h2,
		CCD_TX_GAP   = 3'h4
	} ccd_tx_e;
endpackage
`default_nettype wire

// file: core/ccd_if.sv
// Serial control channel wires between controller and device
`default_nettype none
interface ccd_if;
	logic bit_clk;        // Bit clock, data stable at its rise
	logic frame_pulse;    // High for the first bit slot of a frame
	logic ctrl_serial_in; // Control byte, bit 0 first
	modport ctl (output bit_clk, output frame_pulse, output ctrl_serial_in);
	modport dev (input bit_clk, input frame_pulse, input ctrl_serial_in);
endinterface
`default_nettype wire

// file: core/ccd_device.sv
// Device end: control byte decode, control and diagnostic registers
`default_nettype none
module ccd_device (
	input  wire logic       core_clk,           // System clock
	input  wire logic       resetn,             // Async reset, active low
	ccd_if.dev              link,               // Serial control channel
	output logic            line_rate_sel,      // 1 selects 160 kbit/s
	output logic            sig_chan_in_bearer, // Signalling byte in first bearer slot
	output logic            scrambler_tx_en,    // Transmit prescrambler on
	output logic            scrambler_rx_en,    // Receive deprescrambler on
	output logic            fast_adapt,         // Fast echo canceller adaptation
	output logic            tx_housekeeping_bit, // Housekeeping bit to send
	output logic            force_resync_loss,  // Force receiver out of sync
	output logic            poly_exchange,      // Swap scrambler polynomials
	output logic            line_out_mute,      // Line output held at bias
	output logic [1:0]      loop_sel,           // Active loopback code
	input  wire logic [7:0] sig_byte,           // Signalling byte of this frame
	input  wire logic [7:0] b1_byte,            // First bearer byte of this frame
	output logic [7:0]      tx_b1_byte,         // Byte sent in first bearer slot
	output logic [1:0]      tx_sig_bits,        // Bits sent in signalling positions
	input  wire logic       bearer_serial_in,   // System bearer input bit
	input  wire logic       rx_bearer_bit,      // Bearer bit received from line
	input  wire logic       line_tx_bit,        // Transmit bit toward the line
	input  wire logic       line_rx_bit,        // Receive bit from the line
	output logic            bearer_serial_out,  // System bearer output bit
	output logic            bearer_core_in,     // Bearer bit into transmit path
	output logic            line_rx_core,       // Receive bit into receive path
	output logic            line_drive_out      // Line driver data, low when muted
);
	typedef struct packed {
		logic [1:0]      bclk_s;
		logic [1:0]      fp_s;
		logic [1:0]      dat_s;
		logic            bclk_prev;
		ccd_pkg::ccd_rx_e st;
		logic [2:0]      cnt;
		logic [7:0]      shreg;
		logic [7:0]      ctrl;
		logic [7:0]      diag;
		logic [7:0]      tx_b1;
		logic [1:0]      tx_sig;
		logic            bso;
		logic            bci;
		logic            lrc;
		logic            ldo;
	} ccd_dev_s;

	ccd_dev_s state_q;
	ccd_dev_s state_d;

	// Upper nibble all ones means a default mode
	function automatic logic is_default(input logic [7:0] b);
		is_default = (b & ccd_pkg::DEF_MASK) == ccd_pkg::DEF_MASK;
	endfunction

	// Preset control value chosen by bit 3
	function automatic logic [7:0] default_val(input logic [7:0] b);
		default_val = b[ccd_pkg::LINE_RATE_BIT] ? ccd_pkg::DEF2_VAL : ccd_pkg::DEF1_VAL;
	endfunction

	// Next state
	always_comb begin
		logic       rise;
		logic [7:0] b;
		logic [1:0] sel;
		logic [1:0] lb;
		rise = 1'b0;
		b = 8'h00;
		sel = 2'h0;
		lb = 2'h0;
		state_d = state_q;
		// Two-stage synchronisers on the link pins
		// Only the second stage is read; the first may be metastable
		state_d.bclk_s = {state_q.bclk_s[0], link.bit_clk};
		state_d.fp_s = {state_q.fp_s[0], link.frame_pulse};
		state_d.dat_s = {state_q.dat_s[0], link.ctrl_serial_in};
		state_d.bclk_prev = state_q.bclk_s[1];
		rise = state_q.bclk_s[1] & ~state_q.bclk_prev;
		b = {state_q.dat_s[1], state_q.shreg[7:1]};
		sel = {b[ccd_pkg::SEL1_BIT], b[ccd_pkg::SEL0_BIT]};
		if (rise) begin
			// A frame pulse restarts the byte even if one was cut short
			if (state_q.fp_s[1]) begin
				state_d.st = ccd_pkg::CCD_RX_SHIFT;
				state_d.cnt = 3'h0;
				// Pulse-time clear; a byte later in the frame survives it
				if (!state_q.ctrl[ccd_pkg::DIAG_CLEAR_N_BIT]) begin
					state_d.diag = ccd_pkg::DIAG_RST;
				end
			end else begin
				unique case (state_q.st)
					ccd_pkg::CCD_RX_WAIT: begin
						state_d.st = ccd_pkg::CCD_RX_WAIT;
					end
					ccd_pkg::CCD_RX_SHIFT: begin
						state_d.shreg = b;
						state_d.cnt = state_q.cnt + 3'h1;
						if (state_q.cnt == 3'(ccd_pkg::BYTE_BITS - 1)) begin
							state_d.st = ccd_pkg::CCD_RX_WAIT;
							// Route the completed byte
							// Static high reads as all ones with select 11
							// Other bytes with select codes 01 and 11 fall through and are dropped
							if (b == ccd_pkg::ALL_ONES) begin
								state_d.ctrl = ccd_pkg::DEF2_VAL;
							end else if (sel == ccd_pkg::SEL_CTRL) begin
								if (is_default(b)) begin
									state_d.ctrl = default_val(b);
								end else begin
									state_d.ctrl = b;
								end
							end else if (sel == ccd_pkg::SEL_DIAG) begin
								if (is_default(b)) begin
									state_d.ctrl = default_val(b);
									state_d.diag = ccd_pkg::DIAG_RST;
								end else begin
									state_d.diag = b;
								end
							end
						end
					end
					default: begin
						state_d.st = ccd_pkg::CCD_RX_WAIT;
					end
				endcase
			end
		end
		// Signalling placement by rate and in-bearer mode
		// Outputs lag their inputs by one clock
		if (state_q.ctrl[ccd_pkg::SIG_IN_BEARER_BIT]) begin
			state_d.tx_b1 = sig_byte;
			state_d.tx_sig = 2'h0;
		end else begin
			state_d.tx_b1 = b1_byte;
			if (state_q.ctrl[ccd_pkg::LINE_RATE_BIT]) begin
				state_d.tx_sig = sig_byte[1:0];
			end else begin
				state_d.tx_sig = {1'b0, sig_byte[0]};
			end
		end
		// Loopback paths
		// Each code swaps one source in; code 00 keeps every normal path
		lb = {state_q.diag[ccd_pkg::LOOP_HI_BIT], state_q.diag[ccd_pkg::LOOP_LO_BIT]};
		state_d.bso = (lb == ccd_pkg::LB_SYS) ? bearer_serial_in : rx_bearer_bit;
		state_d.lrc = (lb == ccd_pkg::LB_LINE) ? line_tx_bit : line_rx_bit;
		state_d.bci = (lb == ccd_pkg::LB_FAR) ? rx_bearer_bit : bearer_serial_in;
		state_d.ldo = state_q.diag[ccd_pkg::LINE_MUTE_BIT] ? 1'b0 : line_tx_bit;
	end

	// State register
	// Reset leaves 80 kbit/s and a diag register cleared every frame
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= '{
				bclk_s: 2'h0, fp_s: 2'h0, dat_s: 2'h0, bclk_prev: 1'b0,
				st: ccd_pkg::CCD_RX_WAIT, cnt: 3'h0, shreg: 8'h00,
				ctrl: ccd_pkg::CTRL_RST, diag: ccd_pkg::DIAG_RST,
				tx_b1: 8'h00, tx_sig: 2'h0, bso: 1'b0, bci: 1'b0, lrc: 1'b0, ldo: 1'b0
			};
		end else begin
			state_q <= state_d;
		end
	end

	// Register fields onto the block controls
	// Both scrambler enables share one bit so they never part
	assign line_rate_sel = state_q.ctrl[ccd_pkg::LINE_RATE_BIT];
	assign sig_chan_in_bearer = state_q.ctrl[ccd_pkg::SIG_IN_BEARER_BIT];
	assign scrambler_tx_en = state_q.ctrl[ccd_pkg::SCRAMBLER_BIT];
	assign scrambler_rx_en = state_q.ctrl[ccd_pkg::SCRAMBLER_BIT];
	assign fast_adapt = state_q.ctrl[ccd_pkg::FAST_ADAPT_BIT];
	assign tx_housekeeping_bit = state_q.ctrl[ccd_pkg::TX_HK_BIT];
	assign force_resync_loss = state_q.diag[ccd_pkg::RESYNC_LOSS_BIT];
	assign poly_exchange = state_q.diag[ccd_pkg::POLY_EXCH_BIT];
	assign line_out_mute = state_q.diag[ccd_pkg::LINE_MUTE_BIT];
	assign loop_sel = {state_q.diag[ccd_pkg::LOOP_HI_BIT], state_q.diag[ccd_pkg::LOOP_LO_BIT]};

	// Data path outputs
	// All taken straight from flops, no logic after the register
	assign tx_b1_byte = state_q.tx_b1;
	assign tx_sig_bits = state_q.tx_sig;
	assign bearer_serial_out = state_q.bso;
	assign bearer_core_in = state_q.bci;
	assign line_rx_core = state_q.lrc;
	assign line_drive_out = state_q.ldo;
endmodule
`default_nettype wire

// file: core/ccd_controller.sv
// Controller end: frames the control channel and sends one byte per frame
`default_nettype none
module ccd_controller #(
	parameter int BIT_CYC = ccd_pkg::BIT_CYC // Clock cycles per bit slot
) (
	input  wire logic       core_clk,     // System clock
	input  wire logic       resetn,       // Async reset, active low
	ccd_if.ctl              link,         // Serial control channel
	input  wire logic       ctrl_wr,      // Request to send ctrl_byte
	input  wire logic [7:0] ctrl_byte,    // line_control value, select bits forced
	output logic            ctrl_busy,    // High while a control byte is pending
	input  wire logic [7:0] diag_byte,    // diagnostic_control value
	input  wire logic       diag_hold,    // Send the diagnostic byte in every frame with no control byte pending
	input  wire logic       static_mode,  // Hold serial line at static_level
	input  wire logic       static_level, // Level for static default selection
	output logic            fast_active,  // Fast adaptation being forced
	output logic            frame_start   // One-cycle pulse at each frame start
);
	localparam int CW = $clog2(BIT_CYC + 1);
	localparam logic [CW-1:0] LAST_CYC = CW'(BIT_CYC - 1);
	localparam logic [CW-1:0] HALF_CYC = CW'(BIT_CYC / 2);

	typedef struct packed {
		ccd_pkg::ccd_tx_e    st;
		logic [CW-1:0]       cyc;
		logic [4:0]          slot;
		logic                pend;
		logic                started;
		logic [7:0]          ctrl;
		logic [ccd_pkg::FAST_W-1:0] fast_cnt;
		logic [7:0]          shreg;
		logic                bclk;
		logic                fp;
		logic                dat;
		logic                fs;
	} ccd_ctl_s;

	ccd_ctl_s state_q;
	ccd_ctl_s state_d;

	// Next state
	always_comb begin
		logic [4:0] nslot;
		logic [7:0] cbyte;
		nslot = 5'h0;
		cbyte = 8'h00;
		state_d = state_q;
		state_d.fs = 1'b0;
		// Accept a control write when nothing is pending
		if (ctrl_wr && !state_q.pend) begin
			state_d.pend = 1'b1;
			state_d.ctrl = ctrl_byte;
		end
		// Control byte with select bits low and forced fast adaptation
		cbyte = state_q.ctrl;
		cbyte[ccd_pkg::SEL0_BIT] = 1'b0;
		cbyte[ccd_pkg::SEL1_BIT] = 1'b0;
		cbyte[ccd_pkg::FAST_ADAPT_BIT] = state_q.ctrl[ccd_pkg::FAST_ADAPT_BIT] | (state_q.fast_cnt != '0);
		// Bit clock low in first half, rising mid-slot
		if (state_q.cyc == LAST_CYC) begin
			state_d.cyc = '0;
			state_d.bclk = 1'b0;
			nslot = (state_q.slot == 5'(ccd_pkg::FRAME_BITS - 1)) ? 5'h0 : state_q.slot + 5'h1;
			state_d.slot = nslot;
			if (nslot == 5'h0) begin
				state_d.st = ccd_pkg::CCD_TX_PULSE;
				state_d.fp = 1'b1;
				state_d.fs = 1'b1;
				// Pick the byte of the next frame
				if (state_q.pend) begin
					state_d.shreg = cbyte;
					state_d.pend = 1'b0;
				end else if (diag_hold) begin
					state_d.shreg = {diag_byte[7:2], ccd_pkg::SEL_DIAG};
				end else begin
					state_d.shreg = cbyte;
				end
				// Fast adaptation span from rate at first frame
				if (!state_q.started) begin
					state_d.started = 1'b1;
					state_d.fast_cnt = state_q.ctrl[ccd_pkg::LINE_RATE_BIT]
						? ccd_pkg::FAST_W'(ccd_pkg::FAST_FRAMES_160)
						: ccd_pkg::FAST_W'(ccd_pkg::FAST_FRAMES_80);
				end else if (state_q.fast_cnt != '0) begin
					state_d.fast_cnt = state_q.fast_cnt - ccd_pkg::FAST_W'(1);
				end
			end else if (nslot < 5'(ccd_pkg::DATA_FIRST + ccd_pkg::BYTE_BITS)) begin
				state_d.st = ccd_pkg::CCD_TX_DATA;
				state_d.fp = 1'b0;
			end else begin
				state_d.st = ccd_pkg::CCD_TX_GAP;
				state_d.fp = 1'b0;
			end
			// Serial data, bit 0 first
			unique case (state_d.st)
				ccd_pkg::CCD_TX_PULSE: state_d.dat = 1'b0;
				ccd_pkg::CCD_TX_DATA: begin
					state_d.dat = state_q.shreg[0];
					state_d.shreg = {1'b0, state_q.shreg[7:1]};
				end
				ccd_pkg::CCD_TX_GAP: state_d.dat = 1'b0;
				default: state_d.dat = 1'b0;
			endcase
			if (static_mode) begin
				state_d.dat = static_level;
			end
		end else begin
			state_d.cyc = state_q.cyc + CW'(1);
			state_d.bclk = state_d.cyc >= HALF_CYC; // Level matches the position it is shown at
		end
	end

	// State register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= '{
				st: ccd_pkg::CCD_TX_GAP, cyc: '0, slot: 5'(ccd_pkg::FRAME_BITS - 1),
				pend: 1'b0, started: 1'b0, ctrl: ccd_pkg::CTRL_RST, fast_cnt: '0,
				shreg: 8'h00, bclk: 1'b0, fp: 1'b0, dat: 1'b0, fs: 1'b0
			};
		end else begin
			state_q <= state_d;
		end
	end

	// Outputs
	assign link.bit_clk = state_q.bclk;
	assign link.frame_pulse = state_q.fp;
	assign link.ctrl_serial_in = state_q.dat;
	assign ctrl_busy = state_q.pend;
	assign fast_active = state_q.fast_cnt != '0;
	assign frame_start = state_q.fs;
endmodule
`default_nettype wire

// file: tb/ccd_asserts.sv
// Checker for link framing and device output paths
`default_nettype none
module ccd_asserts #(
	parameter int BIT_CYC = ccd_pkg::BIT_CYC // Cycles per bit slot
) (
	input wire logic       core_clk,           // Clock
	input wire logic       resetn,             // Reset, active low
	input wire logic       bit_clk,            // Link bit clock
	input wire logic       frame_pulse,        // Link frame pulse
	input wire logic       ctrl_serial_in,     // Link data
	input wire logic       line_rate_sel,      // Rate select
	input wire logic       sig_chan_in_bearer, // Signalling in bearer
	input wire logic       scrambler_tx_en,    // Tx scrambler
	input wire logic       scrambler_rx_en,    // Rx scrambler
	input wire logic       line_out_mute,      // Line mute
	input wire logic [1:0] loop_sel,           // Loop code
	input wire logic [7:0] sig_byte,           // Signalling byte
	input wire logic [7:0] b1_byte,            // Bearer byte
	input wire logic [7:0] tx_b1_byte,         // Bearer slot out
	input wire logic [1:0] tx_sig_bits,        // Signalling out
	input wire logic       bearer_serial_in,   // Bearer in
	input wire logic       rx_bearer_bit,      // Bearer from line
	input wire logic       line_tx_bit,        // Tx bit
	input wire logic       line_rx_bit,        // Rx bit
	input wire logic       bearer_serial_out,  // Bearer out
	input wire logic       bearer_core_in,     // Tx path in
	input wire logic       line_rx_core,       // Rx path in
	input wire logic       line_drive_out      // Line driver
);
	localparam int FRAME_LEN = ccd_pkg::FRAME_BITS * BIT_CYC;
	logic        fp_q, seen_q, rise;
	logic [15:0] pos_q, p;
	logic [1:0]  sig_lo;
	// Position inside the frame
	assign rise   = frame_pulse & ~fp_q;
	assign p      = rise ? 16'h0000 : pos_q;
	assign sig_lo = sig_byte[1:0];
	// Frame position tracker
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			fp_q   <= 1'b0;
			seen_q <= 1'b0;
			pos_q  <= 16'h0000;
		end else begin
			fp_q   <= frame_pulse;
			seen_q <= seen_q | rise;
			pos_q  <= p + 16'h0001;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	property p_period;
		rise && seen_q |-> pos_q == FRAME_LEN;
	endproperty
	a_period: assert property (p_period) else $error("frame period wrong");
	property p_pulse;
		(seen_q || rise) |-> frame_pulse == (p < BIT_CYC);
	endproperty
	a_pulse: assert property (p_pulse) else $error("frame pulse length wrong");
	property p_bitclk;
		(seen_q || rise) |-> bit_clk == ((p % BIT_CYC) >= BIT_CYC / 2);
	endproperty
	a_bitclk: assert property (p_bitclk) else $error("bit clock phase wrong");
	property p_stable;
		seen_q && (p % BIT_CYC) != 0 |-> $stable(ctrl_serial_in);
	endproperty
	a_stable: assert property (p_stable) else $error("data moved inside slot");
	property p_scram;
		scrambler_tx_en == scrambler_rx_en;
	endproperty
	a_scram: assert property (p_scram) else $error("scrambler enables differ");
	property p_mute;
		$past(resetn) |-> line_drive_out == ($past(line_out_mute) ? 1'b0 : $past(line_tx_bit));
	endproperty
	a_mute: assert property (p_mute) else $error("line driver wrong");
	property p_sys;
		$past(resetn) |-> bearer_serial_out ==
			($past(loop_sel) == ccd_pkg::LB_SYS ? $past(bearer_serial_in) : $past(rx_bearer_bit));
	endproperty
	a_sys: assert property (p_sys) else $error("system loop wrong");
	property p_line;
		$past(resetn) |-> line_rx_core ==
			($past(loop_sel) == ccd_pkg::LB_LINE ? $past(line_tx_bit) : $past(line_rx_bit));
	endproperty
	a_line: assert property (p_line) else $error("line loop wrong");
	property p_far;
		$past(resetn) |-> bearer_core_in ==
			($past(loop_sel) == ccd_pkg::LB_FAR ? $past(rx_bearer_bit) : $past(bearer_serial_in));
	endproperty
	a_far: assert property (p_far) else $error("far loop wrong");
	property p_sig;
		$past(resetn) |-> tx_sig_bits == ($past(sig_chan_in_bearer) ? 2'h0 :
			$past(line_rate_sel) ? $past(sig_lo) : {1'b0, $past(sig_byte[0])});
	endproperty
	a_sig: assert property (p_sig) else $error("signalling bits wrong");
	property p_b1;
		$past(resetn) |-> tx_b1_byte == ($past(sig_chan_in_bearer) ? $past(sig_byte) : $past(b1_byte));
	endproperty
	a_b1: assert property (p_b1) else $error("bearer slot byte wrong");
	c_frame: cover property (rise && seen_q);
	c_far: cover property (loop_sel == ccd_pkg::LB_FAR);
	c_mute: cover property (line_out_mute && line_tx_bit);
endmodule
`default_nettype wire

// file: tb/cchannel_control_diag_regs_tb_top.sv
// Bench joining controller and device over the control channel
`default_nettype none
module cchannel_control_diag_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BC     = 4;
	localparam int SETTLE = 12 * BC;
	localparam int LIMIT  = 90000;
	logic        core_clk = 1'b0;
	logic        resetn, ctrl_wr, ctrl_busy, diag_hold, static_mode, static_level, frame_start, fast_active;
	logic [7:0]  ctrl_byte, diag_byte, sig_byte, b1_byte, tx_b1_byte, cgot, dgot;
	logic [15:0] stim = 16'h0000;
	logic        line_rate_sel, sig_chan_in_bearer, scrambler_tx_en, scrambler_rx_en, fast_adapt;
	logic        tx_housekeeping_bit, force_resync_loss, poly_exchange, line_out_mute;
	logic        bearer_serial_in, rx_bearer_bit, line_tx_bit, line_rx_bit;
	logic        bearer_serial_out, bearer_core_in, line_rx_core, line_drive_out;
	logic [1:0]  loop_sel, tx_sig_bits;
	logic [7:0]  cv [9];
	logic [7:0]  dv [7];
	int          failures = 0;
	int          n_tests  = 0;
	int          cycles   = 0;
	ccd_if u_ccd_if ();
	ccd_controller #(.BIT_CYC(BC)) u_ccd_controller (.core_clk(core_clk), .resetn(resetn), .link(u_ccd_if),
		.ctrl_wr(ctrl_wr), .ctrl_byte(ctrl_byte), .ctrl_busy(ctrl_busy), .diag_byte(diag_byte),
		.diag_hold(diag_hold), .static_mode(static_mode), .static_level(static_level),
		.fast_active(fast_active), .frame_start(frame_start));
	ccd_device u_ccd_device (.core_clk(core_clk), .resetn(resetn), .link(u_ccd_if),
		.line_rate_sel(line_rate_sel), .sig_chan_in_bearer(sig_chan_in_bearer),
		.scrambler_tx_en(scrambler_tx_en), .scrambler_rx_en(scrambler_rx_en), .fast_adapt(fast_adapt),
		.tx_housekeeping_bit(tx_housekeeping_bit), .force_resync_loss(force_resync_loss),
		.poly_exchange(poly_exchange), .line_out_mute(line_out_mute), .loop_sel(loop_sel),
		.sig_byte(sig_byte), .b1_byte(b1_byte), .tx_b1_byte(tx_b1_byte), .tx_sig_bits(tx_sig_bits),
		.bearer_serial_in(bearer_serial_in), .rx_bearer_bit(rx_bearer_bit), .line_tx_bit(line_tx_bit),
		.line_rx_bit(line_rx_bit), .bearer_serial_out(bearer_serial_out), .bearer_core_in(bearer_core_in),
		.line_rx_core(line_rx_core), .line_drive_out(line_drive_out));
	ccd_asserts #(.BIT_CYC(BC)) u_ccd_asserts (.core_clk(core_clk), .resetn(resetn),
		.bit_clk(u_ccd_if.bit_clk), .frame_pulse(u_ccd_if.frame_pulse),
		.ctrl_serial_in(u_ccd_if.ctrl_serial_in), .line_rate_sel(line_rate_sel),
		.sig_chan_in_bearer(sig_chan_in_bearer), .scrambler_tx_en(scrambler_tx_en),
		.scrambler_rx_en(scrambler_rx_en), .line_out_mute(line_out_mute), .loop_sel(loop_sel),
		.sig_byte(sig_byte), .b1_byte(b1_byte), .tx_b1_byte(tx_b1_byte), .tx_sig_bits(tx_sig_bits),
		.bearer_serial_in(bearer_serial_in), .rx_bearer_bit(rx_bearer_bit), .line_tx_bit(line_tx_bit),
		.line_rx_bit(line_rx_bit), .bearer_serial_out(bearer_serial_out), .bearer_core_in(bearer_core_in),
		.line_rx_core(line_rx_core), .line_drive_out(line_drive_out));
	// Register views for compares
	assign cgot = {2'h0, tx_housekeeping_bit, fast_adapt, scrambler_tx_en, scrambler_rx_en, sig_chan_in_bearer,
		line_rate_sel};
	assign dgot = {3'h0, line_out_mute, poly_exchange, force_resync_loss, loop_sel};
	// Changing bearer and signalling inputs
	assign sig_byte = stim[15:8];
	assign b1_byte  = stim[7:0] ^ 8'h5A;
	assign {bearer_serial_in, rx_bearer_bit, line_tx_bit, line_rx_bit} = {stim[3], stim[6], stim[9], stim[12]};
	always #4 core_clk = ~core_clk;
	// Stimulus counter, moved just after each edge
	always @(posedge core_clk) begin
		#1;
		stim <= stim + 16'h3A75;
	end
	// Hang guard
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			failures++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Wait n frame starts, then s cycles into the frame
	task automatic frames(input int n, input int s);
		repeat (n) begin
			do begin
				tick();
			end while (frame_start !== 1'b1);
		end
		repeat (s) tick();
	endtask
	task automatic wr_ctrl(input logic [7:0] b);
		while (ctrl_busy !== 1'b0) tick();
		ctrl_byte = b;
		ctrl_wr   = 1'b1;
		tick();
		chk({7'h00, ctrl_busy}, 8'h01);
		ctrl_wr = 1'b0;
		frames(2, SETTLE);
	endtask
	// Expected control view, default patterns folded in
	function automatic logic [7:0] cexp(input logic [7:0] b);
		logic [7:0] e;
		e = ((b & ccd_pkg::DEF_MASK) == ccd_pkg::DEF_MASK) ? {4'h0, b[3], 3'h0} : b;
		return {2'h0, e[7:5], e[5:3]};
	endfunction
	// Main sequence
	initial begin
		resetn       = 1'b0;
		ctrl_wr      = 1'b0;
		ctrl_byte    = 8'h00;
		diag_byte    = 8'h00;
		diag_hold    = 1'b0;
		static_mode  = 1'b0;
		static_level = 1'b0;
		cv = '{8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'hE8, 8'hF4, 8'hF8, 8'hFC};
		dv = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h40, 8'h00};
		repeat (6) @(posedge core_clk);
		#1;
		chk(cgot | dgot, 8'h00);
		resetn    = 1'b1;
		ctrl_byte = 8'h08;
		ctrl_wr   = 1'b1;
		tick();
		ctrl_wr = 1'b0;
		frames(235, SETTLE);
		chk({6'h00, fast_active, fast_adapt}, 8'h03);
		frames(10, SETTLE);
		chk({6'h00, fast_active, fast_adapt}, 8'h00);
		$display("test fast adapt done");
		for (int i = 0; i < 9; i++) begin
			wr_ctrl(cv[i]);
			chk(cgot, cexp(cv[i]));
		end
		$display("test control fields done");
		wr_ctrl(8'h04);
		diag_hold = 1'b1;
		for (int i = 0; i < 7; i++) begin
			diag_byte = dv[i];
			frames(2, SETTLE);
			chk(dgot, {3'h0, dv[i][6:2]});
		end
		chk(cgot, cexp(8'h04));
		$display("test diagnostic fields done");
		diag_byte = 8'h4C;
		frames(2, SETTLE);
		diag_hold = 1'b0;
		frames(2, SETTLE);
		chk(dgot, {3'h0, diag_byte[6:2]});
		wr_ctrl(8'h00);
		chk(dgot, 8'h00);
		diag_hold = 1'b1;
		frames(2, SETTLE);
		chk(dgot, {3'h0, diag_byte[6:2]});
		frames(1, 3 * BC);
		chk(dgot, 8'h00);
		diag_hold = 1'b0;
		$display("test diagnostic clear done");
		wr_ctrl(8'hE8);
		static_mode  = 1'b1;
		static_level = 1'b1;
		frames(2, SETTLE);
		chk(cgot, cexp(8'hFF));
		static_level = 1'b0;
		frames(2, SETTLE);
		chk(cgot, cexp(8'h00));
		static_mode = 1'b0;
		$display("test static level done");
		diag_byte = 8'hF8;
		diag_hold = 1'b1;
		frames(2, SETTLE);
		chk(cgot | dgot, 8'h01);
		diag_hold = 1'b0;
		$display("test diagnostic default done");
		// Second reset in mid-run, then the 80 kbit/s fast span
		resetn = 1'b0;
		repeat (6) tick();
		chk(cgot | dgot | {7'h00, ctrl_busy}, 8'h00);
		resetn    = 1'b1;
		ctrl_byte = 8'h00;
		ctrl_wr   = 1'b1;
		tick();
		ctrl_wr = 1'b0;
		frames(245, SETTLE);
		chk({6'h00, fast_active, fast_adapt}, 8'h03);
		$display("test slow fast adapt done");
		stop_test();
	end
endmodule
`default_nettype wire
